// >>> hw/sacrc_ctrl.sv
// Operation
// - rising edges of low/high start inputs sample channels 1-4 and 5-8
// - start edge puts channels into hold, then internal clock converts them
// - readout works regardless of start input levels
// - reset clears all digital logic asynchronously while asserted
// - reset during conversion abandons it; data becomes invalid
// - reset during a read clears every output data register to zero
// - parallel modes: bus enabled only while chip select and strobe are low
// - serial transfers are referenced to the shift clock rising edge
// - chip select rising puts all data outputs into high impedance
// - chip select falling begins a new transfer frame in every mode
// - parallel mode uses 16-bit bus, byte mode lower eight lines
// - serial mode: chip select falling drives msb of previous result
// - three ratio select inputs set oversampling ratio, top bit most significant
// - busy rises only after rising edges on both start inputs
// - while busy, start input activity is ignored
// - busy stays high until results are latched, then falls
// - first channel flag leaves high impedance at chip select fall, marks channel 1
// - interface select low parallel; high serial or byte by byte select
// - each result is 18-bit two's complement, same for both ranges
// - parallel: flag high at first strobe fall, low at third
// - serial: flag low at eighteenth shift clock falling edge
`default_nettype none
module sacrc_ctrl
  import sacrc_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start_convert_low_half,
  input wire logic start_convert_high_half,
  input wire logic cs_b,
  input wire logic read_or_shift_clock,
  input wire logic interface_select,
  input wire logic byte_mode_select,
  input wire logic [2:0] oversample_ratio_sel,
  input wire logic [NCH*RES_W-1:0] sample_in,
  output logic busy,
  output logic hold_low,
  output logic hold_high,
  output logic conv_clk,
  output logic data_valid,
  output logic [PAR_W-1:0] parallel_data_bus,
  output logic parallel_data_oe,
  output logic serial_out_a,
  output logic serial_out_b,
  output logic serial_oe,
  output logic first_channel_flag,
  output logic first_channel_flag_oe
);

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] filt;
    logic [PIN_W-1:0] prev;
    sacrc_state_t st;
    logic seen_lo;
    logic seen_hi;
    logic [CNT_W-1:0] cnt;
    logic conv_clk;
    logic [NCH*RES_W-1:0] res;
    logic valid;
    logic [3:0] ch;
    logic [4:0] part;
    logic [PAR_W-1:0] par;
    logic sa;
    logic sb;
    logic flag;
  } sacrc_regs_t;

  sacrc_regs_t r_q;
  sacrc_regs_t r_d;

  function automatic logic [RES_W-1:0] get_res(input logic [NCH*RES_W-1:0] all,
                                               input logic [3:0] c);
    logic [RES_W-1:0] v;
    v = '0;
    for (int i = 0; i < NCH; i++) begin
      if (c == 4'(i)) begin
        v = all[i*RES_W +: RES_W];
      end
    end
    return v;
  endfunction

  logic [PIN_W-1:0] pins;
  logic rise_lo;
  logic rise_hi;
  logic lo_hit;
  logic hi_hit;
  logic cs_lvl;
  logic cs_fall;
  logic rd_lvl;
  logic rd_fall;
  sacrc_mode_t mode;
  logic [2:0] os_sel;
  logic [CNT_W-1:0] conv_len;
  logic res0_msb;

  assign pins = {oversample_ratio_sel, byte_mode_select, interface_select,
                 read_or_shift_clock, cs_b, start_convert_high_half,
                 start_convert_low_half};

  // edges come from the filtered copy, so pin glitches lasting one sample do not count
  assign rise_lo = r_q.filt[PIN_LO] & ~r_q.prev[PIN_LO];
  assign rise_hi = r_q.filt[PIN_HI] & ~r_q.prev[PIN_HI];
  assign lo_hit = r_q.seen_lo | rise_lo;
  assign hi_hit = r_q.seen_hi | rise_hi;
  assign cs_lvl = r_q.filt[PIN_CS];
  assign cs_fall = ~r_q.filt[PIN_CS] & r_q.prev[PIN_CS];
  assign rd_lvl = r_q.filt[PIN_RD];
  assign rd_fall = ~r_q.filt[PIN_RD] & r_q.prev[PIN_RD];
  assign os_sel = r_q.filt[PIN_OS +: 3];
  assign res0_msb = r_q.res[RES_MSB];

  // oversampling stretches the conversion by the ratio 2^os
  assign conv_len = CNT_W'(CONV_LEN) << os_sel;

  always_comb begin
    if (!r_q.filt[PIN_IFS]) begin
      mode = SACRC_PAR;
    end else if (r_q.filt[PIN_BYS]) begin
      mode = SACRC_BYTE;
    end else begin
      mode = SACRC_SER;
    end
  end

  always_comb begin
    logic [4:0] last;
    logic [4:0] npart;
    logic [3:0] nch;
    logic [RES_W-1:0] cur;
    logic [RES_W-1:0] ra;
    logic [RES_W-1:0] rb;
    last = LAST_PAR;
    npart = '0;
    nch = '0;
    cur = '0;
    ra = '0;
    rb = '0;
    r_d = r_q;

    r_d.s1 = pins;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    if (r_q.s2 == r_q.s3) begin
      r_d.filt = r_q.s3;
    end
    r_d.prev = r_q.filt;

    unique case (r_q.st)
      SACRC_IDLE: begin
        r_d.conv_clk = 1'b0;
        if (rise_lo) begin
          r_d.seen_lo = 1'b1;
        end
        if (rise_hi) begin
          r_d.seen_hi = 1'b1;
        end
        if (lo_hit && hi_hit) begin
          r_d.st = SACRC_CONV;
          r_d.cnt = conv_len;
        end
      end
      SACRC_CONV: begin
        // start edges are not looked at here, so they cannot re-arm
        r_d.conv_clk = ~r_q.conv_clk;
        if (r_q.cnt <= CNT_W'(1)) begin
          r_d.res = sample_in;
          r_d.valid = 1'b1;
          r_d.seen_lo = 1'b0;
          r_d.seen_hi = 1'b0;
          r_d.conv_clk = 1'b0;
          r_d.st = SACRC_IDLE;
        end else begin
          r_d.cnt = r_q.cnt - CNT_W'(1);
        end
      end
    endcase

    unique case (mode)
      SACRC_PAR: last = LAST_PAR;
      SACRC_BYTE: last = LAST_BYTE;
      SACRC_SER: last = LAST_SER;
    endcase

    // next piece position; channel saturates once all are read
    if (r_q.part == last) begin
      npart = '0;
      nch = (r_q.ch < 4'(NCH)) ? r_q.ch + 4'h1 : r_q.ch;
    end else begin
      npart = r_q.part + 5'h01;
      nch = r_q.ch;
    end

    // readout does not look at the start inputs at all
    if (cs_fall) begin
      r_d.ch = '0;
      r_d.part = '0;
      r_d.flag = (mode == SACRC_SER);
      if (mode == SACRC_SER) begin
        ra = get_res(r_q.res, 4'h0);
        rb = get_res(r_q.res, 4'(HALF_CH));
        r_d.sa = ra[RES_MSB];
        r_d.sb = rb[RES_MSB];
      end
    end else if (!cs_lvl && rd_fall && mode != SACRC_SER) begin
      cur = get_res(r_q.res, r_q.ch);
      if (mode == SACRC_PAR) begin
        if (r_q.part == 5'h00) begin
          r_d.par = cur[RES_MSB:2];
        end else begin
          r_d.par = {cur[1:0], 14'h0000};
        end
      end else begin
        unique case (r_q.part)
          5'h00: r_d.par = {8'h00, cur[RES_MSB:10]};
          5'h01: r_d.par = {8'h00, cur[9:2]};
          default: r_d.par = {8'h00, cur[1:0], 6'h00};
        endcase
      end
      // high while this strobe fetches a channel 1 piece
      r_d.flag = (r_q.ch == 4'h0);
      r_d.part = npart;
      r_d.ch = nch;
    end else if (!cs_lvl && rd_fall && mode == SACRC_SER) begin
      // update after the falling edge so data is steady at the rising edge
      r_d.part = npart;
      r_d.ch = nch;
      r_d.flag = (nch == 4'h0);
      if (nch < 4'(HALF_CH)) begin
        ra = get_res(r_q.res, nch);
        rb = get_res(r_q.res, nch + 4'(HALF_CH));
        r_d.sa = ra[5'(RES_MSB) - npart];
        r_d.sb = rb[5'(RES_MSB) - npart];
      end else begin
        r_d.sa = 1'b0;
        r_d.sb = 1'b0;
      end
    end
  end

  // async reset drops conversion, results and read state alike
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '{s1: PIN_RST, s2: PIN_RST, s3: PIN_RST, filt: PIN_RST, prev: PIN_RST,
               st: SACRC_IDLE, par: PAR_RST, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign busy = (r_q.st == SACRC_CONV);
  assign hold_low = r_q.seen_lo | busy;
  assign hold_high = r_q.seen_hi | busy;
  assign conv_clk = r_q.conv_clk;
  assign data_valid = r_q.valid;
  assign parallel_data_bus = r_q.par;
  assign parallel_data_oe = !cs_lvl && !rd_lvl && mode != SACRC_SER;
  assign serial_out_a = r_q.sa;
  assign serial_out_b = r_q.sb;
  assign serial_oe = !cs_lvl && mode == SACRC_SER;
  assign first_channel_flag = r_q.flag;
  assign first_channel_flag_oe = !cs_lvl;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_both_hit;
    lo_hit && hi_hit;
  endsequence

  sequence s_cs_falls_serial;
    cs_fall && mode == SACRC_SER;
  endsequence

  property p_busy_needs_both;
    $rose(busy) |-> $past(lo_hit) && $past(hi_hit);
  endproperty
  a_busy_needs_both: assert property (p_busy_needs_both)
    else $error("busy rose without both start edges");

  property p_busy_follows_both;
    (r_q.st == SACRC_IDLE) ##0 s_both_hit |=> busy;
  endproperty
  a_busy_follows_both: assert property (p_busy_follows_both)
    else $error("busy missing after both start edges");

  property p_ignore_starts;
    busy && (rise_lo || rise_hi) && r_q.cnt > CNT_W'(1) |=> busy && $stable(r_q.res);
  endproperty
  a_ignore_starts: assert property (p_ignore_starts)
    else $error("start edge disturbed a running conversion");

  property p_latch_on_fall;
    $fell(busy) |-> r_q.res == $past(sample_in) && data_valid;
  endproperty
  a_latch_on_fall: assert property (p_latch_on_fall)
    else $error("busy fell without latching results");

  property p_conv_clock_runs;
    busy [*2] |-> conv_clk != $past(conv_clk);
  endproperty
  a_conv_clock_runs: assert property (p_conv_clock_runs)
    else $error("conversion clock stalled");

  property p_results_hold;
    !busy |=> $stable(r_q.res);
  endproperty
  a_results_hold: assert property (p_results_hold)
    else $error("results changed outside conversion");

  property p_cs_tristate;
    $rose(cs_lvl) |-> !parallel_data_oe && !serial_oe && !first_channel_flag_oe;
  endproperty
  a_cs_tristate: assert property (p_cs_tristate)
    else $error("outputs still driven after chip select rose");

  property p_serial_msb;
    s_cs_falls_serial |=> serial_out_a == $past(res0_msb) && first_channel_flag;
  endproperty
  a_serial_msb: assert property (p_serial_msb)
    else $error("serial frame did not start with channel 1 msb");

  property p_flag_par_third;
    mode == SACRC_PAR && !cs_lvl && rd_fall && r_q.ch == 4'h1 && r_q.part == 5'h00
      |=> !first_channel_flag;
  endproperty
  a_flag_par_third: assert property (p_flag_par_third)
    else $error("flag not low at third strobe fall");

  property p_flag_ser_18;
    mode == SACRC_SER && !cs_lvl && rd_fall && r_q.ch == 4'h0 && r_q.part == LAST_SER
      |=> !first_channel_flag;
  endproperty
  a_flag_ser_18: assert property (p_flag_ser_18)
    else $error("flag not low at eighteenth shift fall");

endmodule
`default_nettype wire

// >>> hw/sacrc_pkg.sv
`default_nettype none
package sacrc_pkg;

  // channel and result geometry
  localparam int NCH = 8;
  localparam int HALF_CH = 4;
  localparam int RES_W = 18;
  localparam int RES_MSB = 17;
  localparam int PAR_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 24;

  // synchronised pin vector layout
  localparam int PIN_W = 9;
  localparam int PIN_LO = 0;
  localparam int PIN_HI = 1;
  localparam int PIN_CS = 2;
  localparam int PIN_RD = 3;
  localparam int PIN_IFS = 4;
  localparam int PIN_BYS = 5;
  localparam int PIN_OS = 6;

  // pieces read per channel, minus one
  localparam logic [4:0] LAST_PAR = 5'h01;
  localparam logic [4:0] LAST_BYTE = 5'h02;
  localparam logic [4:0] LAST_SER = 5'h11;

  // reset values
  localparam logic [PIN_W-1:0] PIN_RST = 9'h00c;
  localparam logic [PAR_W-1:0] PAR_RST = 16'h0000;

  // conversion time at oversampling ratio 1
  localparam int CLK_MHZ = 10;
  localparam int CONV_TIME_NS = 4000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic {
    SACRC_IDLE,
    SACRC_CONV
  } sacrc_state_t;

  typedef enum logic [1:0] {
    SACRC_PAR,
    SACRC_BYTE,
    SACRC_SER
  } sacrc_mode_t;

endpackage
`default_nettype wire

// >>> sim/sacrc_host_model.sv
`default_nettype none
module sacrc_host_model
  import sacrc_pkg::*;
(
  input wire logic clk,
  output logic cs_b,
  output logic read_or_shift_clock,
  input wire logic [PAR_W-1:0] parallel_data_bus,
  input wire logic parallel_data_oe,
  input wire logic serial_out_a,
  input wire logic serial_out_b,
  input wire logic first_channel_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // parked high: deselected, strobe idle, shift clock still between frames
  initial begin
    cs_b = 1'b1;
    read_or_shift_clock = 1'b1;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic frame(input logic open);
    cs_b <= ~open;
    wait_cyc(8);
  endtask
  // strobe low 8 cycles; bus taken only while the device drives it
  task automatic read_piece(output logic [PAR_W-1:0] d, output logic f);
    read_or_shift_clock <= 1'b0;
    wait_cyc(8);
    d = parallel_data_oe ? parallel_data_bus : ~parallel_data_bus;
    f = first_channel_flag;
    read_or_shift_clock <= 1'b1;
    wait_cyc(8);
  endtask
  // 800 ns period; bits taken while high, just before the falling edge
  task automatic shift_bit(output logic a, output logic b, output logic f);
    a = serial_out_a;
    b = serial_out_b;
    f = first_channel_flag;
    read_or_shift_clock <= 1'b0;
    wait_cyc(4);
    read_or_shift_clock <= 1'b1;
    wait_cyc(4);
  endtask
endmodule
`default_nettype wire

// >>> sim/test_sacrc_ctrl.sv
`default_nettype none
module test_sacrc_ctrl
  import sacrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CLEN = 4;
  logic clk;
  logic rst_b;
  logic st_lo;
  logic st_hi;
  logic ifs;
  logic bys;
  logic [2:0] os;
  logic [NCH*RES_W-1:0] smp;
  logic cs_b, rd, busy, hold_lo, hold_hi, valid, poe, sa, sb, soe, flag, foe, cclk;
  logic [PAR_W-1:0] bus;
  logic [RES_W-1:0] pend_m, lat_m;
  int n_mismatch = 0;
  int num_checks = 0;
  int tick = 0;

  sacrc_ctrl #(.CONV_LEN(CLEN)) i_sacrc_ctrl (
    .clk(clk), .rst_b(rst_b), .start_convert_low_half(st_lo),
    .start_convert_high_half(st_hi), .cs_b(cs_b), .read_or_shift_clock(rd),
    .interface_select(ifs), .byte_mode_select(bys), .oversample_ratio_sel(os),
    .sample_in(smp), .busy(busy), .hold_low(hold_lo), .hold_high(hold_hi),
    .conv_clk(cclk), .data_valid(valid), .parallel_data_bus(bus),
    .parallel_data_oe(poe), .serial_out_a(sa), .serial_out_b(sb), .serial_oe(soe),
    .first_channel_flag(flag), .first_channel_flag_oe(foe));
  sacrc_host_model i_sacrc_host_model (
    .clk(clk), .cs_b(cs_b), .read_or_shift_clock(rd), .parallel_data_bus(bus),
    .parallel_data_oe(poe), .serial_out_a(sa), .serial_out_b(sb),
    .first_channel_flag(flag));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [PAR_W-1:0] got, input logic [PAR_W-1:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  function automatic logic [RES_W-1:0] chv(input int i);
    return 18'h2c3a5 + RES_W'(i) * 18'h05a17;
  endfunction
  task automatic apply(input logic [RES_W-1:0] m);
    for (int i = 0; i < NCH; i++) smp[i*RES_W +: RES_W] <= chv(i) ^ m;
    pend_m = m;
  endtask
  task automatic wait_busy();
    for (int n = 0; n < 20 && busy !== 1'b1; n++) cyc(1);
  endtask
  task automatic convert(input logic [2:0] r);
    int n;
    int hi;
    n = 0;
    hi = 0;
    os <= r;
    st_lo <= 1'b1;
    // halves sequenced apart only with oversampling off
    if (r == 3'h0) begin
      cyc(8);
      chk(hold_lo, 1'b1, "hold low");
      chk(hold_hi, 1'b0, "hold high");
      chk(busy, 1'b0, "busy early");
    end
    st_hi <= 1'b1;
    wait_busy();
    while (busy === 1'b1 && n < 400) begin
      if (cclk === 1'b1) hi++;
      cyc(1);
      n++;
    end
    chk(PAR_W'(n), PAR_W'(CLEN << r), "busy length");
    chk(PAR_W'(hi), PAR_W'((CLEN << r) / 2), "conv clk");
    chk(valid, 1'b1, "valid");
    lat_m = pend_m;
  endtask

  always @(posedge clk) begin
    tick <= tick + 1;
    if (tick == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    logic [PAR_W-1:0] d, e;
    logic [RES_W-1:0] r;
    logic a, b, f;
    rst_b <= 1'b0;
    st_lo <= 1'b0;
    st_hi <= 1'b0;
    ifs <= 1'b0;
    bys <= 1'b0;
    os <= 3'h0;
    smp <= '0;
    cyc(2);
    rst_b <= 1'b1;
    // pin filter needs several edges before the first start
    cyc(5);
    chk({busy, valid, poe, foe, soe}, 5'h00, "reset state");
    apply(18'h00000);
    convert(3'h0);
    // fresh core data must not reach the latched results
    apply(18'h3ffff);
    i_sacrc_host_model.frame(1'b1);
    chk(foe, 1'b1, "flag oe");
    for (int i = 0; i < 2 * NCH + 1; i++) begin
      i_sacrc_host_model.read_piece(d, f);
      r = chv(i / 2) ^ lat_m;
      e = i >= 2 * NCH ? 16'h0000 : i[0] ? {r[1:0], 14'h0000} : r[17:2];
      chk(d, e, "par data");
      chk(f, i < 2, "par flag");
    end
    i_sacrc_host_model.frame(1'b0);
    chk({poe, foe}, 2'h0, "released");
    st_lo <= 1'b0;
    st_hi <= 1'b0;
    cyc(8);
    convert(3'h2);
    st_lo <= 1'b0;
    st_hi <= 1'b0;
    ifs <= 1'b1;
    bys <= 1'b1;
    cyc(8);
    i_sacrc_host_model.frame(1'b1);
    for (int i = 0; i < 4; i++) begin
      i_sacrc_host_model.read_piece(d, f);
      r = chv(i / 3) ^ lat_m;
      e = {8'h00, i % 3 == 0 ? r[17:10] : i % 3 == 1 ? r[9:2] : {r[1:0], 6'h00}};
      chk(d, e, "byte data");
      chk(f, i < 3, "byte flag");
    end
    i_sacrc_host_model.frame(1'b0);
    bys <= 1'b0;
    cyc(8);
    i_sacrc_host_model.frame(1'b1);
    for (int i = 0; i < RES_W + 1; i++) begin
      i_sacrc_host_model.shift_bit(a, b, f);
      r = chv(i / RES_W) ^ lat_m;
      chk(a, r[RES_MSB - i % RES_W], "ser a");
      r = chv(HALF_CH + i / RES_W) ^ lat_m;
      chk(b, r[RES_MSB - i % RES_W], "ser b");
      chk(f, i < RES_W, "ser flag");
    end
    i_sacrc_host_model.frame(1'b0);
    chk({soe, foe}, 2'h0, "ser released");
    ifs <= 1'b0;
    os <= 3'h3;
    cyc(8);
    i_sacrc_host_model.frame(1'b1);
    st_lo <= 1'b1;
    st_hi <= 1'b1;
    cyc(5);
    wait_busy(); // no strobe while busy
    cyc(3);
    rst_b <= 1'b0;
    st_lo <= 1'b0;
    st_hi <= 1'b0;
    cyc(2);
    chk(busy, 1'b0, "busy in reset");
    rst_b <= 1'b1;
    cyc(8);
    chk({busy, valid}, 2'h0, "aborted");
    i_sacrc_host_model.read_piece(d, f);
    chk(d, 16'h0000, "cleared data");
    i_sacrc_host_model.frame(1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
